// *** design/asbs_align.sv ***
// Byte alignment of read data by size, low address bits and port width
`timescale 1ns/100ps
module asbs_align
  import asbs_pkg::*;
(
  input  wire logic [1:0]  size,
  input  wire logic [1:0]  low_addr,
  input  wire logic [1:0]  ack_code,
  input  wire logic [31:0] bus_data,
  output logic      [31:0] aligned,
  output logic      [2:0]  count
);

  function automatic logic [31:0] asbs_pick(input logic [31:0] d,
                                            input logic [1:0]  lane,
                                            input logic [2:0]  cnt);
    logic [31:0] r;
    logic [7:0]  b;
    r = DATA_RESET;
    for (int i = 0; i < LANES; i++) begin
      if (i < int'(cnt)) begin
        b = 8'(d >> (BYTE_W * (LANES - 1 - (int'(lane) + i))));
        r = r | (32'(b) << (BYTE_W * (int'(cnt) - 1 - i)));
      end
    end
    return r;
  endfunction

  logic [2:0] want;
  logic [2:0] avail;
  logic [1:0] lane;

  always_comb begin
    want  = (size == SIZE_LONG) ? CNT_LONG : {1'b0, size};
    avail = CNT_ONE;
    lane  = 2'h0;
    case (ack_code)
      ACK_PORT32: begin
        avail = CNT_LONG - {1'b0, low_addr};
        lane  = low_addr;
      end
      ACK_PORT16: begin
        avail = CNT_HALF - {2'h0, low_addr[0]};
        lane  = {1'b0, low_addr[0]};
      end
      default: begin
        avail = CNT_ONE;
        lane  = 2'h0;
      end
    endcase
    count   = (want < avail) ? want : avail;
    aligned = asbs_pick(bus_data, lane, count);
  end

endmodule

// *** design/asbs_pkg.sv ***
// Shared constants and types for the bus read cycle sequencer
package asbs_pkg;

  typedef enum logic [3:0] {
    ASBS_IDLE = 4'h0,
    ASBS_S0   = 4'h1,
    ASBS_S1   = 4'h2,
    ASBS_S2   = 4'h3,
    ASBS_W1   = 4'h4,
    ASBS_W2   = 4'h5,
    ASBS_S3   = 4'h6,
    ASBS_S4   = 4'h7,
    ASBS_S5   = 4'h8
  } asbs_state_type;

  localparam int          BYTE_W      = 8;
  localparam int          LANES       = 4;
  localparam logic [1:0]  SIZE_LONG   = 2'h0;
  localparam logic [1:0]  SIZE_BYTE   = 2'h1;
  localparam logic [1:0]  SIZE_WORD   = 2'h2;
  localparam logic [1:0]  SIZE_THREE  = 2'h3;
  // Acknowledge pair {hi, lo}, active low
  localparam logic [1:0]  ACK_PORT32  = 2'h0;
  localparam logic [1:0]  ACK_PORT16  = 2'h1;
  localparam logic [1:0]  ACK_PORT8   = 2'h2;
  localparam logic [1:0]  ACK_NONE    = 2'h3;
  localparam logic [2:0]  CNT_LONG    = 3'h4;
  localparam logic [2:0]  CNT_HALF    = 3'h2;
  localparam logic [2:0]  CNT_ONE     = 3'h1;
  localparam logic [31:0] ADDR_RESET  = 32'h00000000;
  localparam logic [31:0] DATA_RESET  = 32'h00000000;
  localparam logic [2:0]  SPACE_RESET = 3'h0;
  localparam logic [1:0]  SIZE_RESET  = 2'h0;
  localparam logic [2:0]  MIN_CYCLE_HALVES = 3'h5;

endpackage

// *** design/asbs_seq.sv ***
// Read cycle sequencer driving the asynchronous external bus
`timescale 1ns/100ps
module asbs_seq
  import asbs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  input  wire logic [2:0]  rd_space,
  input  wire logic [1:0]  rd_size,
  input  wire logic        rd_first,
  output logic             rd_ready,
  output logic             rd_done,
  output logic [31:0]      rd_data,
  output logic [2:0]       rd_bytes,
  output logic             rd_error,
  output logic             rd_retry,
  output logic             bus_clk_out,
  output logic [31:0]      addr_out,
  output logic [2:0]       addr_space_code,
  output logic             xfer_size_hi,
  output logic             xfer_size_lo,
  output logic             read_not_write,
  output logic             addr_strobe_n,
  output logic             data_strobe_n,
  output logic             data_buffer_en_n,
  output logic             ext_cycle_start_n,
  output logic             operand_cycle_start_n,
  input  wire logic        xfer_ack_hi_n,
  input  wire logic        xfer_ack_lo_n,
  input  wire logic        bus_error_n,
  input  wire logic        halt_n,
  input  wire logic [31:0] data_in
);

  asbs_state_type state_reg;
  asbs_state_type state_next;
  logic        phase_reg;
  logic [35:0] sync1_reg;
  logic [35:0] sync2_reg;
  logic [1:0]  ack_s;
  logic        bus_error_n_s;
  logic        halt_s;
  logic [31:0] data_s;
  logic        term;
  logic        sample;
  logic [1:0]  ack_code_reg;
  logic        err_reg;
  logic        hlt_reg;
  logic        first_reg;
  logic [31:0] aligned;
  logic [2:0]  count;
  logic        as_next;
  logic        data_buffer_en_n_next;
  logic [31:0] addr_reg;
  logic [2:0]  space_reg;
  logic [1:0]  size_reg;
  logic        as_reg;
  logic        ds_reg;
  logic        data_buffer_en_n_reg;
  logic        ecs_reg;
  logic        ocs_reg;
  logic        done_reg;
  logic [31:0] data_reg;
  logic [2:0]  bytes_reg;
  logic        error_reg;
  logic        retry_reg;

  // Input de-skew: two flip-flops on every slave input
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= {4'hF, DATA_RESET};
      sync2_reg <= {4'hF, DATA_RESET};
    end else begin
      sync1_reg <= {xfer_ack_hi_n, xfer_ack_lo_n, bus_error_n, halt_n, data_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign ack_s  = sync2_reg[35:34];
  assign bus_error_n_s = sync2_reg[33];
  assign halt_s = sync2_reg[32];
  assign data_s = sync2_reg[31:0];

  // Falling bus clock edges end S2 and each second wait half
  assign sample = (state_reg == ASBS_S2) || (state_reg == ASBS_W2);
  assign term   = (ack_s != ACK_NONE) || !bus_error_n_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  assign rd_ready = (state_reg == ASBS_IDLE) && !phase_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ASBS_IDLE: if (rd_req && rd_ready) state_next = ASBS_S0;
      ASBS_S0:   state_next = ASBS_S1;
      ASBS_S1:   state_next = ASBS_S2;
      ASBS_S2:   state_next = term ? ASBS_S3 : ASBS_W1;
      ASBS_W1:   state_next = ASBS_W2;
      ASBS_W2:   state_next = term ? ASBS_S3 : ASBS_W1;
      ASBS_S3:   state_next = ASBS_S4;
      ASBS_S4:   state_next = ASBS_S5;
      ASBS_S5:   state_next = ASBS_IDLE;
      default:   state_next = ASBS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ASBS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Recognition of the acknowledge pair and early bus error
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_code_reg <= ACK_NONE;
      err_reg      <= 1'b0;
      hlt_reg      <= 1'b0;
    end else if (state_next == ASBS_S0) begin
      ack_code_reg <= ACK_NONE;
      err_reg      <= 1'b0;
      hlt_reg      <= 1'b0;
    end else if (sample && term) begin
      ack_code_reg <= ack_s;
      err_reg      <= !bus_error_n_s;
      hlt_reg      <= !bus_error_n_s && !halt_s;
    end
  end

  // Request latch: address, space, size held through S5 and after
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_reg  <= ADDR_RESET;
      space_reg <= SPACE_RESET;
      size_reg  <= SIZE_RESET;
      first_reg <= 1'b0;
    end else if (state_next == ASBS_S0) begin
      addr_reg  <= rd_addr;
      space_reg <= rd_space;
      size_reg  <= rd_size;
      first_reg <= rd_first;
    end
  end

  assign as_next   = (state_next != ASBS_IDLE) && (state_next != ASBS_S0)
                     && (state_next != ASBS_S5);
  assign data_buffer_en_n_next = as_next && (state_next != ASBS_S1);

  // Bus control strobes registered from the next state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      as_reg   <= 1'b1;
      ds_reg   <= 1'b1;
      data_buffer_en_n_reg <= 1'b1;
      ecs_reg  <= 1'b1;
      ocs_reg  <= 1'b1;
    end else begin
      as_reg   <= !as_next;
      ds_reg   <= !as_next;
      data_buffer_en_n_reg <= !data_buffer_en_n_next;
      ecs_reg  <= (state_next != ASBS_S0);
      ocs_reg  <= !((state_next == ASBS_S0) && rd_first);
    end
  end

  asbs_align u_align (
    .size     (size_reg),
    .low_addr (addr_reg[1:0]),
    .ack_code (ack_code_reg),
    .bus_data (data_s),
    .aligned  (aligned),
    .count    (count)
  );

  // Data capture on the falling edge ending S4
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_reg  <= 1'b0;
      data_reg  <= DATA_RESET;
      bytes_reg <= 3'h0;
      error_reg <= 1'b0;
      retry_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == ASBS_S4);
      if (state_reg == ASBS_S4) begin
        data_reg  <= aligned;
        bytes_reg <= (ack_code_reg == ACK_NONE) ? 3'h0 : count;
        error_reg <= err_reg || !bus_error_n_s;
        retry_reg <= hlt_reg || (!bus_error_n_s && !halt_s);
      end
    end
  end

  assign rd_done               = done_reg;
  assign rd_data               = data_reg;
  assign rd_bytes              = bytes_reg;
  assign rd_error              = error_reg;
  assign rd_retry              = retry_reg;
  assign bus_clk_out           = phase_reg;
  assign addr_out              = addr_reg;
  assign addr_space_code       = space_reg;
  assign xfer_size_hi          = size_reg[1];
  assign xfer_size_lo          = size_reg[0];
  assign read_not_write        = 1'b1;
  assign addr_strobe_n         = as_reg;
  assign data_strobe_n         = ds_reg;
  assign data_buffer_en_n      = data_buffer_en_n_reg;
  assign ext_cycle_start_n     = ecs_reg;
  assign operand_cycle_start_n = ocs_reg;

  // Checks
  logic [2:0] halves_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      halves_reg <= 3'h0;
    end else if (state_next == ASBS_S0) begin
      halves_reg <= 3'h0;
    end else if (halves_reg != 3'h7) begin
      halves_reg <= halves_reg + 3'h1;
    end
  end

  property p_min_cycle;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S5) |-> (halves_reg >= MIN_CYCLE_HALVES);
  endproperty
  a_min_cycle: assert property (p_min_cycle) else $error("cycle shorter than three clocks");

  property p_no_wait;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S2 && ack_s != ACK_NONE)
        |=> (state_reg == ASBS_S3) ##1 (state_reg == ASBS_S4) ##1 (state_reg == ASBS_S5);
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait inserted despite acknowledge");

  property p_capture;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S4) |=> rd_done && (rd_data == $past(aligned));
  endproperty
  a_capture: assert property (p_capture) else $error("data not captured after S4");

  property p_s0;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S0) |-> !ext_cycle_start_n && (operand_cycle_start_n == !first_reg)
        && data_buffer_en_n && addr_strobe_n && bus_clk_out;
  endproperty
  a_s0: assert property (p_s0) else $error("state 0 outputs wrong");

  property p_s1;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S1) |-> !addr_strobe_n && !data_strobe_n && ext_cycle_start_n
        && operand_cycle_start_n && data_buffer_en_n;
  endproperty
  a_s1: assert property (p_s1) else $error("state 1 outputs wrong");

  property p_s2;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S2) |-> !data_buffer_en_n;
  endproperty
  a_s2: assert property (p_s2) else $error("buffer not enabled in S2");

  property p_wait;
    @(posedge core_clk) disable iff (rst)
      (sample && ack_s == ACK_NONE && bus_error_n_s) |=> state_reg == ASBS_W1 ##1 state_reg == ASBS_W2;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state missing");

  property p_s5;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S5) |-> addr_strobe_n && data_strobe_n && data_buffer_en_n
        && $stable(addr_out) && $stable(addr_space_code) && read_not_write;
  endproperty
  a_s5: assert property (p_s5) else $error("state 5 outputs wrong");

  property p_bus_error_n;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ASBS_S2 && !bus_error_n_s) |-> ##3 (rd_done && rd_error);
  endproperty
  a_bus_error_n: assert property (p_bus_error_n) else $error("bus error not reported");

  c_fast:  cover property (@(posedge core_clk) disable iff (rst)
    (state_reg == ASBS_S2 && ack_s != ACK_NONE) ##3 rd_done);
  c_wait:  cover property (@(posedge core_clk) disable iff (rst)
    (state_reg == ASBS_W2) ##1 (state_reg == ASBS_S3));
  c_error: cover property (@(posedge core_clk) disable iff (rst) rd_done && rd_error);
  c_retry: cover property (@(posedge core_clk) disable iff (rst) rd_done && rd_retry);

endmodule

// *** testbench/asbs_slave_model.sv ***
// Behavioural slave answering read cycles with set delay, port width and errors
`timescale 1ns/100ps
module asbs_slave_model
  import asbs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        addr_strobe_n,
  input  wire logic        ext_cycle_start_n,
  input  wire logic [3:0]  ack_delay,
  input  wire logic [1:0]  port_code,
  input  wire logic [1:0]  err_mode,
  input  wire logic [31:0] word,
  output logic             xfer_ack_hi_n,
  output logic             xfer_ack_lo_n,
  output logic             bus_error_n,
  output logic             halt_n,
  output logic [31:0]      data_in
);
  logic [3:0] cnt_reg  = 4'h0;
  logic       resp_reg = 1'b0;
  logic       late_reg = 1'b0;
  logic       ack_on;
  logic       err_on;

  // Zero delay answers from state 0, else after delay falling edges of strobe low
  always @(negedge core_clk) begin
    cnt_reg  <= addr_strobe_n ? 4'h0 : cnt_reg + 4'h1;
    resp_reg <= addr_strobe_n ? (ack_delay == 4'h0 && !ext_cycle_start_n)
                              : (resp_reg || cnt_reg >= ack_delay);
    late_reg <= resp_reg && !addr_strobe_n;
  end

  assign ack_on        = resp_reg && (err_mode == 2'h0 || err_mode == 2'h3);
  assign err_on        = resp_reg && (err_mode == 2'h1 || err_mode == 2'h2);
  assign xfer_ack_hi_n = ack_on ? port_code[1] : 1'b1;
  assign xfer_ack_lo_n = ack_on ? port_code[0] : 1'b1;
  assign bus_error_n   = !(err_on || (late_reg && err_mode == 2'h3));
  assign halt_n        = !((resp_reg && err_mode == 2'h2) || (late_reg && err_mode == 2'h3));
  // Released lanes show the inverse of the last word
  assign data_in       = resp_reg ? word : ~word;
endmodule

// *** testbench/test_asbs_seq.sv ***
// Self-checking bench for the bus read cycle sequencer
`timescale 1ns/100ps
module test_asbs_seq
  import asbs_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd_req = 1'b0;
  logic [31:0] rd_addr = 32'h0;
  logic [2:0]  rd_space = 3'h0;
  logic [1:0]  rd_size = 2'h0;
  logic        rd_first = 1'b0;
  logic [3:0]  ack_delay = 4'h0;
  logic [1:0]  port_code = 2'h0;
  logic [1:0]  err_mode = 2'h0;
  logic [31:0] word = 32'h0;
  logic        rd_ready, rd_done, rd_error, rd_retry, bus_clk_out, read_not_write;
  logic [31:0] rd_data, addr_out, data_in;
  logic [2:0]  rd_bytes, addr_space_code;
  logic        xfer_size_hi, xfer_size_lo, addr_strobe_n, data_strobe_n, data_buffer_en_n;
  logic        ext_cycle_start_n, operand_cycle_start_n;
  logic        xfer_ack_hi_n, xfer_ack_lo_n, bus_error_n, halt_n;
  int          n_errors = 0;
  int          checks_done = 0;

  always #2.5 core_clk = ~core_clk;

  asbs_seq i_dut (.core_clk(core_clk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_space(rd_space), .rd_size(rd_size), .rd_first(rd_first), .rd_ready(rd_ready),
    .rd_done(rd_done), .rd_data(rd_data), .rd_bytes(rd_bytes), .rd_error(rd_error),
    .rd_retry(rd_retry), .bus_clk_out(bus_clk_out), .addr_out(addr_out),
    .addr_space_code(addr_space_code), .xfer_size_hi(xfer_size_hi),
    .xfer_size_lo(xfer_size_lo), .read_not_write(read_not_write),
    .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
    .data_buffer_en_n(data_buffer_en_n), .ext_cycle_start_n(ext_cycle_start_n),
    .operand_cycle_start_n(operand_cycle_start_n), .xfer_ack_hi_n(xfer_ack_hi_n),
    .xfer_ack_lo_n(xfer_ack_lo_n), .bus_error_n(bus_error_n), .halt_n(halt_n),
    .data_in(data_in));

  asbs_slave_model i_slave (.core_clk(core_clk), .addr_strobe_n(addr_strobe_n),
    .ext_cycle_start_n(ext_cycle_start_n), .ack_delay(ack_delay), .port_code(port_code),
    .err_mode(err_mode), .word(word), .xfer_ack_hi_n(xfer_ack_hi_n),
    .xfer_ack_lo_n(xfer_ack_lo_n), .bus_error_n(bus_error_n), .halt_n(halt_n),
    .data_in(data_in));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One read cycle, walked state by state from the bus pins
  task automatic read(input logic [31:0] a, input logic [1:0] sz, input logic first,
                      input logic [3:0] dl, input logic [1:0] pc, input logic [1:0] em,
                      input int waits);
    int n;
    int nb;
    int off;
    int pb;
    logic [31:0] ex;
    n = 0;
    rd_addr = a;
    rd_space = a[2:0] ^ 3'h5;
    rd_size = sz;
    rd_first = first;
    ack_delay = dl;
    port_code = pc;
    err_mode = em;
    word = 32'hA1B2C3D4 ^ a;
    rd_req = 1'b1;
    while (ext_cycle_start_n !== 1'b0 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    rd_req = 1'b0;
    check(n < 8, 1'b1, "cycle start");
    check(addr_out, a, "s0 address");
    check({addr_space_code, xfer_size_hi, xfer_size_lo, read_not_write, data_buffer_en_n},
          {rd_space, sz, 2'h3}, "s0 controls");
    check({operand_cycle_start_n, bus_clk_out, rd_ready}, {!first, 2'h2}, "s0 starts");
    @(negedge core_clk);
    check({addr_strobe_n, data_strobe_n, ext_cycle_start_n, operand_cycle_start_n,
           bus_clk_out}, 5'h06, "s1 strobes");
    @(negedge core_clk);
    check(data_buffer_en_n, 1'b0, "s2 buffer");
    n = 2;
    while (rd_done !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    check(n, 5 + 2 * waits, "cycle length");
    check({addr_strobe_n, data_strobe_n, data_buffer_en_n}, 3'h7, "s5 strobes");
    check(addr_out, a, "s5 address hold");
    pb = (pc == ACK_PORT32) ? 4 : (pc == ACK_PORT16) ? 2 : 1;
    off = (pc == ACK_PORT32) ? a[1:0] : (pc == ACK_PORT16) ? a[0] : 0;
    nb = (sz == SIZE_LONG) ? 4 : sz;
    if (nb > pb - off) nb = pb - off;
    ex = (word << (8 * off)) >> (8 * (4 - nb));
    if (em == 2'h0 || em == 2'h3) begin
      check(rd_data, ex, "read data");
      check(rd_bytes, nb, "byte count");
    end
    if (em == 2'h1 || em == 2'h2) check(rd_bytes, 3'h0, "error bytes");
    check({rd_error, rd_retry}, (em == 2'h0) ? 2'h0 : (em == 2'h1) ? 2'h2 : 2'h3,
          "error flags");
    @(negedge core_clk);
    check(rd_done, 1'b0, "done pulse");
  endtask

  task automatic t_no_wait();
    read(32'h00001000, SIZE_LONG, 1'b1, 4'h0, ACK_PORT32, 2'h0, 0);
  endtask

  task automatic t_waits();
    for (int d = 1; d <= 4; d++) read(32'h2000 + 4 * d, SIZE_LONG, 1'b0, 4'(d), ACK_PORT32, 2'h0,
                                      (d + 2) / 2);
  endtask

  task automatic t_align();
    // Each entry holds low address, size code and acknowledge code
    logic [5:0] cases [8] = '{6'h01, 6'h02, 6'h18, 6'h1C, 6'h34, 6'h15, 6'h30, 6'h29};
    for (int i = 0; i < 8; i++) read({28'h0000300, 2'h0, cases[i][5:4]}, cases[i][3:2],
                                     i[0], 4'h0, cases[i][1:0], 2'h0, 0);
  endtask

  task automatic t_errors();
    for (int e = 1; e <= 3; e++) read(32'h4000 + 4 * e, SIZE_WORD, 1'b1, 4'h0, ACK_PORT32,
                                      2'(e), 0);
  endtask

  // Reset in mid-run clears status and strobes, then a read follows at once
  task automatic t_reset();
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    check({addr_strobe_n, data_strobe_n, data_buffer_en_n, ext_cycle_start_n,
           operand_cycle_start_n, bus_clk_out}, 6'h3E, "reset strobes");
    check({rd_ready, rd_done, rd_error, rd_retry}, 4'h8, "reset status");
    check(rd_data | addr_out, 32'h0, "reset data");
    rst = 1'b0;
    read(32'h00005000, SIZE_BYTE, 1'b1, 4'h0, ACK_PORT8, 2'h0, 0);
  endtask

  initial begin
    #50000;
    n_errors++;
    close_out();
  end

  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_no_wait();
    t_waits();
    t_align();
    t_errors();
    t_reset();
    close_out();
  end
endmodule
